// [include/itb_pkg.sv]
// Constants for the indicator bank and branch-on-indicator test
package itb_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [11:0] ADDR_STATUS = 12'h000;
  localparam logic [11:0] ADDR_BRANCH = 12'h004;
  localparam logic [11:0] ADDR_TARGET = 12'h008;
  localparam logic [11:0] ADDR_RESULT = 12'h00c;
  localparam logic [11:0] ADDR_MASK = 12'h010;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int F_SEL_LO = 0;
  localparam int F_SEL_TENS = 4;
  localparam int F_NEG = 20;
  localparam int F_BUSY = 0;
  localparam int F_DONE = 1;
  localparam int F_TAKEN = 2;
  localparam int F_ADDR = 4;
  localparam int F_MASK_SET = 0;
  localparam int F_MASK_CLR = 1;
  localparam int TGT_W = 20;
  // ----------------------------------------
  // Indicator codes
  // ----------------------------------------
  localparam int IND_RD = 6;
  localparam int IND_WR = 7;
  localparam int IND_MAR = 8;
  localparam int IND_LAST = 9;
  localparam int IND_HP = 11;
  localparam int IND_EZ = 12;
  localparam int IND_HPEZ = 13;
  localparam int IND_OVF = 14;
  localparam int IND_EXP = 15;
  localparam int IND_MBE = 16;
  localparam int IND_MBO = 17;
  localparam int IND_OPE = 18;
  localparam int IND_ANY = 19;
  localparam int IND_TAS = 21;
  localparam int IND_FRC = 22;
  localparam int IND_AOC = 23;
  localparam int IND_MASK = 26;
  localparam int IND_CE = 27;
  localparam int IND_AOS = 28;
  // ----------------------------------------
  // Indicator groups
  // ----------------------------------------
  localparam logic [31:0] TEST_CLR = 32'h08e7c3c0;
  localparam logic [31:0] CPU_CLR = 32'h00e7dbc0;
  localparam logic [31:0] DC_CLR = 32'h00e41800;
  localparam logic [31:0] ANY_SRC = 32'h00e301c0;
  localparam logic [31:0] INT_SRC = 32'h08ef01c0;
  localparam logic [31:0] RST_VAL = 32'h00000000;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int T_TAKEN = 200;
  localparam int T_NOT = 160;
  localparam int T_GRP_TAKEN = 290;
  localparam int T_GRP_NOT = 150;
  localparam int AO_SETUP_MS = 700;
  localparam int AO_SETUP_CYC = AO_SETUP_MS * CLK_MHZ * 1000;
  // ----------------------------------------
  // Branch sequencer states
  // ----------------------------------------
  typedef enum logic [1:0] {
    ITB_IDLE = 2'b00,
    ITB_EXEC = 2'b01
  } itb_state_t;
endpackage

// [src/itb_indicator_test_branch.sv]
// Indicator bank with branch-on-indicator sequencer behind an APB slave
//
// The register addresses and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
module itb_indicator_test_branch #(
  parameter int UNIT_CYCLES = 1,
  parameter bit FP_PRESENT = 1'b1,
  parameter int AO_SETUP_CYCLES = itb_pkg::AO_SETUP_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] program_sw,
  input wire logic read_err,
  input wire logic write_err,
  input wire logic mar_err,
  input wire logic parity_sw_program,
  input wire logic last_card_done,
  input wire logic arith_valid,
  input wire logic arith_pos,
  input wire logic arith_zero,
  input wire logic overflow_err,
  input wire logic exponent_err,
  input wire logic even_buf_err,
  input wire logic odd_buf_err,
  input wire logic op_entry_key,
  input wire logic tas_err,
  input wire logic func_reg_err,
  input wire logic relay_fail,
  input wire logic ce_switch,
  input wire logic ao_cycle_start,
  input wire logic slew_trim,
  input wire logic disk_check,
  input wire logic cpu_reset_key,
  input wire logic conv_reset_key,
  output logic int_req
);
  localparam int AW = $clog2(AO_SETUP_CYCLES + 1);

  if (UNIT_CYCLES < 1 || UNIT_CYCLES > 225) begin : g_bad_unit
    $error("UNIT_CYCLES out of range");
  end
  if (AO_SETUP_CYCLES < 2) begin : g_bad_setup
    $error("AO_SETUP_CYCLES too small");
  end

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;
  wire logic setup = psel & ~penable;
  wire logic wr_acc = psel & penable & pready_ff & pwrite;
  wire logic hit_status = paddr == itb_pkg::ADDR_STATUS;
  wire logic hit_branch = paddr == itb_pkg::ADDR_BRANCH;
  wire logic hit_target = paddr == itb_pkg::ADDR_TARGET;
  wire logic hit_result = paddr == itb_pkg::ADDR_RESULT;
  wire logic hit_mask = paddr == itb_pkg::ADDR_MASK;
  wire logic hit = hit_status | hit_branch | hit_target | hit_result | hit_mask;

  // ----------------------------------------
  // Indicator view
  // ----------------------------------------
  logic [31:0] ind_ff;
  logic [31:0] view;
  logic [31:0] set_v;
  logic [31:0] clr_v;
  wire logic any_chk = |(ind_ff & itb_pkg::ANY_SRC) | disk_check;

  always_comb begin
    view = ind_ff;
    view[4:1] = program_sw;
    view[itb_pkg::IND_HPEZ] = ind_ff[itb_pkg::IND_HP] | ind_ff[itb_pkg::IND_EZ];
    view[itb_pkg::IND_ANY] = any_chk;
  end

  // ----------------------------------------
  // Branch command decode
  // ----------------------------------------
  itb_pkg::itb_state_t state_ff;
  logic [15:0] cnt_ff;
  logic taken_ff;
  logic done_ff;
  logic [itb_pkg::TGT_W-1:0] target_ff;
  wire logic [3:0] sel_ones = pwdata[itb_pkg::F_SEL_LO +: 4];
  wire logic [3:0] sel_tens = pwdata[itb_pkg::F_SEL_TENS +: 4];
  wire logic neg = pwdata[itb_pkg::F_NEG];
  wire logic [6:0] code = 7'(sel_tens) * 7'd10 + 7'(sel_ones);
  wire logic code_lo = code < 7'h20;
  wire logic sel_on = code_lo & view[code[4:0]];
  wire logic tk = neg ? ~sel_on : sel_on;
  wire logic start = wr_acc & hit_branch & (state_ff == itb_pkg::ITB_IDLE);
  wire logic [31:0] sel_hot = code_lo ? (32'h00000001 << code[4:0]) : 32'h00000000;

  function automatic logic grp_f(input logic [6:0] c);
    grp_f = (c == 7'd18) || (c == 7'd19) || (c >= 7'd21 && c <= 7'd23) ||
            (c >= 7'd27 && c <= 7'd29) || (c >= 7'd40 && c <= 7'd45) ||
            (c >= 7'd48 && c <= 7'd59);
  endfunction

  wire logic grp = grp_f(code);
  wire logic [15:0] len_ord = tk ? 16'(itb_pkg::T_TAKEN * UNIT_CYCLES)
                                 : 16'(itb_pkg::T_NOT * UNIT_CYCLES);
  wire logic [15:0] len_grp = tk ? 16'(itb_pkg::T_GRP_TAKEN * UNIT_CYCLES)
                                 : 16'(itb_pkg::T_GRP_NOT * UNIT_CYCLES);
  wire logic [15:0] nxt_cnt = (grp ? len_grp : len_ord) - 16'h0001;

  // ----------------------------------------
  // Setup timer
  // ----------------------------------------
  logic [AW-1:0] ao_cnt_ff;
  wire logic ao_expire = ind_ff[itb_pkg::IND_AOS] & (ao_cnt_ff == AW'(1));

  // ----------------------------------------
  // Set and clear vectors
  // ----------------------------------------
  wire logic mask_wr = wr_acc & hit_mask;
  always_comb begin
    set_v = 32'h00000000;
    set_v[itb_pkg::IND_RD] = read_err;
    set_v[itb_pkg::IND_WR] = write_err;
    set_v[itb_pkg::IND_MAR] = mar_err & parity_sw_program;
    set_v[itb_pkg::IND_LAST] = last_card_done;
    set_v[itb_pkg::IND_HP] = arith_valid & arith_pos & ~arith_zero;
    set_v[itb_pkg::IND_EZ] = arith_valid & arith_zero;
    set_v[itb_pkg::IND_OVF] = overflow_err;
    set_v[itb_pkg::IND_EXP] = FP_PRESENT & exponent_err;
    set_v[itb_pkg::IND_MBE] = even_buf_err;
    set_v[itb_pkg::IND_MBO] = odd_buf_err;
    set_v[itb_pkg::IND_OPE] = op_entry_key;
    set_v[itb_pkg::IND_TAS] = tas_err;
    set_v[itb_pkg::IND_FRC] = func_reg_err;
    set_v[itb_pkg::IND_AOC] = relay_fail;
    set_v[itb_pkg::IND_MASK] = mask_wr & pwdata[itb_pkg::F_MASK_SET];
    set_v[itb_pkg::IND_CE] = ce_switch;
    set_v[itb_pkg::IND_AOS] = ao_cycle_start;
  end

  always_comb begin
    clr_v = 32'h00000000;
    if (start) begin
      clr_v = sel_hot & itb_pkg::TEST_CLR;
    end
    if (cpu_reset_key) begin
      clr_v = clr_v | itb_pkg::CPU_CLR;
    end
    if (conv_reset_key) begin
      clr_v = clr_v | itb_pkg::DC_CLR;
    end
    clr_v[itb_pkg::IND_MASK] = mask_wr & pwdata[itb_pkg::F_MASK_CLR];
    clr_v[itb_pkg::IND_AOS] = slew_trim | ao_expire;
  end

  // ----------------------------------------
  // Indicator storage
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : g_ind
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ind_ff[gi] <= itb_pkg::RST_VAL[gi];
        end else begin
          ind_ff[gi] <= set_v[gi] | (ind_ff[gi] & ~clr_v[gi]);
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ao_cnt_ff <= '0;
    end else if (ao_cycle_start) begin
      ao_cnt_ff <= AW'(AO_SETUP_CYCLES);
    end else if (ao_cnt_ff != '0) begin
      ao_cnt_ff <= ao_cnt_ff - AW'(1);
    end
  end

  // ----------------------------------------
  // Branch sequencer
  // ----------------------------------------
  // sample selected indicator
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= itb_pkg::ITB_IDLE;
      cnt_ff <= 16'h0000;
      taken_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      unique case (state_ff)
        itb_pkg::ITB_IDLE: begin
          if (start) begin
            state_ff <= itb_pkg::ITB_EXEC;
            cnt_ff <= nxt_cnt;
            taken_ff <= tk;
            done_ff <= 1'b0;
          end
        end
        itb_pkg::ITB_EXEC: begin
          if (cnt_ff == 16'h0000) begin
            state_ff <= itb_pkg::ITB_IDLE;
            done_ff <= 1'b1;
          end else begin
            cnt_ff <= cnt_ff - 16'h0001;
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      target_ff <= '0;
    end else if (wr_acc & hit_target) begin
      target_ff <= pwdata[itb_pkg::TGT_W-1:0];
    end
  end

  // ----------------------------------------
  // Read mux and bus answer
  // ----------------------------------------
  wire logic busy = state_ff == itb_pkg::ITB_EXEC;
  wire logic [itb_pkg::TGT_W-1:0] nxt_addr = taken_ff ? target_ff : '0;
  wire logic [31:0] res_word = {8'h00, nxt_addr, 1'b0, taken_ff, done_ff, busy};
  wire logic [31:0] nxt_rdata =
    pwrite ? 32'h00000000 :
    hit_status ? view :
    hit_target ? {12'h000, target_ff} :
    hit_result ? res_word :
    hit_mask ? {31'h00000000, ind_ff[itb_pkg::IND_MASK]} : 32'h00000000;
  wire logic nxt_int = |(view & itb_pkg::INT_SRC);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
      int_req <= 1'b0;
    end else begin
      pready_ff <= setup;
      pslverr_ff <= setup & ~hit;
      if (setup) begin
        prdata_ff <= nxt_rdata;
      end
      int_req <= nxt_int;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_branch_taken: assert property (
    @(posedge pclk) disable iff (!presetn)
    start |=> taken_ff == $past(tk) && busy)
    else $error("branch decision wrong");
  a_ignore_mods: assert property (
    @(posedge pclk) disable iff (!presetn)
    start && !neg |=> taken_ff == $past(sel_on))
    else $error("modifier digits changed decision");
  a_ord_len: assert property (
    @(posedge pclk) disable iff (!presetn)
    start && tk && !grp |=> cnt_ff == 16'(itb_pkg::T_TAKEN * UNIT_CYCLES - 1))
    else $error("ordinary taken time wrong");
  a_grp_len: assert property (
    @(posedge pclk) disable iff (!presetn)
    start && !tk && grp |=> cnt_ff == 16'(itb_pkg::T_GRP_NOT * UNIT_CYCLES - 1))
    else $error("group not-taken time wrong");
  a_read_check: assert property (
    @(posedge pclk) disable iff (!presetn)
    read_err |=> ind_ff[itb_pkg::IND_RD] && any_chk)
    else $error("read check not raised");
  a_mar_gate: assert property (
    @(posedge pclk) disable iff (!presetn)
    !ind_ff[itb_pkg::IND_MAR] && !parity_sw_program |=> !ind_ff[itb_pkg::IND_MAR])
    else $error("address check set without program switch");
  a_hp_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    ind_ff[itb_pkg::IND_HP] && !cpu_reset_key && !conv_reset_key
      |=> ind_ff[itb_pkg::IND_HP])
    else $error("high positive lost");
  a_op_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    conv_reset_key && !op_entry_key |=> !ind_ff[itb_pkg::IND_OPE])
    else $error("operator entry not cleared");
  a_any_irq: assert property (
    @(posedge pclk) disable iff (!presetn)
    odd_buf_err |=> ##1 int_req)
    else $error("buffer check raised no interrupt");
  a_ce_level: assert property (
    @(posedge pclk) disable iff (!presetn)
    ce_switch |=> ind_ff[itb_pkg::IND_CE])
    else $error("service indicator not set");
  a_setup_off: assert property (
    @(posedge pclk) disable iff (!presetn)
    slew_trim && !ao_cycle_start |=> !ind_ff[itb_pkg::IND_AOS])
    else $error("setup indicator not cleared");
  a_set_wins: assert property (
    @(posedge pclk) disable iff (!presetn)
    start && code == 7'd6 && read_err |=> ind_ff[itb_pkg::IND_RD])
    else $error("set lost against clear");
  a_last_card: assert property (
    @(posedge pclk) disable iff (!presetn)
    last_card_done |=> ind_ff[itb_pkg::IND_LAST])
    else $error("last card not set");
  a_ez_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    ind_ff[itb_pkg::IND_EZ] && !cpu_reset_key && !conv_reset_key
      |=> ind_ff[itb_pkg::IND_EZ])
    else $error("equal zero lost");
  a_test_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    start && code == 7'd7 && !write_err |=> !ind_ff[itb_pkg::IND_WR])
    else $error("write check not cleared by test");
endmodule

// [dv/itb_indicator_test_branch_test.sv]
// Self-checking bench for the indicator bank and branch sequencer
`timescale 1ns/1ps
module itb_indicator_test_branch_test;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic int_req;
  logic [3:0] program_sw = 4'h0;
  logic [16:0] ev = 17'h00000;
  logic parity_sw_program = 1'b0;
  logic arith_pos = 1'b0;
  logic arith_zero = 1'b0;
  logic ce_switch = 1'b0;
  logic disk_check = 1'b0;
  logic [31:0] seed = 32'h00000042;
  logic [32:0] exp_q[$];
  logic [31:0] mask_q[$];
  int bad_count = 0;
  int tests_run = 0;
  int cycles = 0;
  int src_b[7] = '{0, 1, 7, 8, 10, 11, 12};
  int src_c[7] = '{6, 7, 16, 17, 21, 22, 23};

  itb_indicator_test_branch #(.UNIT_CYCLES(1), .FP_PRESENT(1'b1), .AO_SETUP_CYCLES(20))
  i_itb_indicator_test_branch (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .program_sw(program_sw), .read_err(ev[0]), .write_err(ev[1]), .mar_err(ev[2]),
    .parity_sw_program(parity_sw_program), .last_card_done(ev[3]), .arith_valid(ev[4]),
    .arith_pos(arith_pos), .arith_zero(arith_zero), .overflow_err(ev[5]),
    .exponent_err(ev[6]), .even_buf_err(ev[7]), .odd_buf_err(ev[8]),
    .op_entry_key(ev[9]), .tas_err(ev[10]), .func_reg_err(ev[11]), .relay_fail(ev[12]),
    .ce_switch(ce_switch), .ao_cycle_start(ev[13]), .slew_trim(ev[14]),
    .disk_check(disk_check), .cpu_reset_key(ev[15]), .conv_reset_key(ev[16]),
    .int_req(int_req)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  initial begin
    forever #5 pclk = ~pclk;
  end

  task automatic finish_test();
    if (bad_count == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 30000) begin
      bad_count++;
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    tests_run++;
    if (seen !== want) begin
      bad_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic bit grp(input int c);
    return c inside {18, 19, [21:23], [27:29], [40:45], [48:59]};
  endfunction

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] e, input logic [31:0] m, input logic err);
    @(posedge pclk);
    exp_q.push_back({err, e});
    mask_q.push_back(m);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h00000000, 32'h00000000, 1'b0);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
    apb(1'b0, a, 32'h00000000, e, m, 1'b0);
  endtask

  task automatic st(input logic [31:0] e, input logic [31:0] m);
    rd(itb_pkg::ADDR_STATUS, e, m);
  endtask

  task automatic pulse(input int b);
    @(posedge pclk);
    ev[b] <= 1'b1;
    @(posedge pclk);
    ev[b] <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask

  task automatic br(input int code, input logic neg, input logic tk);
    logic [19:0] tgt;
    int n;
    seed = xs(seed);
    tgt = seed[19:0];
    n = grp(code) ? (tk ? itb_pkg::T_GRP_TAKEN : itb_pkg::T_GRP_NOT)
                  : (tk ? itb_pkg::T_TAKEN : itb_pkg::T_NOT);
    wr(itb_pkg::ADDR_TARGET, {12'h000, tgt});
    seed = xs(seed);
    wr(itb_pkg::ADDR_BRANCH, {11'h000, neg, seed[11:0], 4'(code / 10), 4'(code % 10)});
    repeat (n - 5) @(posedge pclk);
    rd(itb_pkg::ADDR_RESULT, 32'h00000001, 32'h00000001);
    repeat (3) @(posedge pclk);
    rd(itb_pkg::ADDR_RESULT, {8'h00, tk ? tgt : 20'h00000, 1'b0, tk, 2'b10},
       32'h00fffff7);
  endtask

  // ----------------------------------------
  // Result monitor
  // ----------------------------------------
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk(32'h00000001, 32'h00000000);
      end else begin
        chk(prdata & mask_q[0], exp_q[0][31:0] & mask_q[0]);
        chk({31'h0, pslverr}, {31'h0, exp_q[0][32]});
        void'(exp_q.pop_front());
        void'(mask_q.pop_front());
      end
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    st(32'h00000000, 32'hffffffff);
    seed = xs(seed);
    program_sw <= seed[3:0];
    repeat (2) @(posedge pclk);
    st({27'h0, seed[3:0], 1'b0}, 32'h0000001e);
    apb(1'b0, 12'h100, 32'h00000000, 32'h00000000, 32'hffffffff, 1'b1);
    wr(itb_pkg::ADDR_STATUS, 32'hffffffff);
    st({27'h0, seed[3:0], 1'b0}, 32'hfffffffe);
    for (int i = 0; i < 7; i++) begin
      pulse(src_b[i]);
      st((32'h1 << src_c[i]) | 32'h00080000, 32'h00fb01c0);
      chk({31'h0, int_req}, 32'h00000001);
      br(src_c[i], 1'b0, 1'b1);
      st(32'h00000000, 32'h00fb01c0);
    end
    chk({31'h0, int_req}, 32'h00000000);
    pulse(2);
    st(32'h00000000, 32'h00000100);
    parity_sw_program <= 1'b1;
    pulse(2);
    st(32'h00080100, 32'h00080100);
    br(8, 1'b1, 1'b0);
    pulse(3);
    st(32'h00000200, 32'h00000200);
    br(9, 1'b0, 1'b1);
    arith_pos <= 1'b1;
    pulse(4);
    st(32'h00002800, 32'h00003800);
    br(11, 1'b0, 1'b1);
    st(32'h00002800, 32'h00003800);
    pulse(16);
    st(32'h00000000, 32'h00003800);
    arith_pos <= 1'b0;
    arith_zero <= 1'b1;
    pulse(4);
    st(32'h00003000, 32'h00003800);
    br(12, 1'b1, 1'b0);
    st(32'h00003000, 32'h00003800);
    pulse(15);
    st(32'h00000000, 32'h00003800);
    pulse(5);
    pulse(6);
    st(32'h0000c000, 32'h0000c000);
    pulse(15);
    st(32'h00000000, 32'h0000c000);
    pulse(9);
    st(32'h00040000, 32'h00040000);
    chk({31'h0, int_req}, 32'h00000001);
    br(18, 1'b1, 1'b0);
    st(32'h00000000, 32'h00040000);
    disk_check <= 1'b1;
    st(32'h00080000, 32'h00080000);
    br(19, 1'b0, 1'b1);
    disk_check <= 1'b0;
    st(32'h00000000, 32'h00080000);
    ce_switch <= 1'b1;
    repeat (2) @(posedge pclk);
    ce_switch <= 1'b0;
    pulse(16);
    pulse(15);
    st(32'h08000000, 32'h08000000);
    br(27, 1'b0, 1'b1);
    st(32'h00000000, 32'h08000000);
    pulse(13);
    st(32'h10000000, 32'h10000000);
    repeat (25) @(posedge pclk);
    st(32'h00000000, 32'h10000000);
    pulse(13);
    pulse(14);
    st(32'h00000000, 32'h10000000);
    wr(itb_pkg::ADDR_MASK, 32'h00000001);
    st(32'h04000000, 32'h04000000);
    wr(itb_pkg::ADDR_MASK, 32'h00000002);
    rd(itb_pkg::ADDR_MASK, 32'h00000000, 32'h00000001);
    wr(itb_pkg::ADDR_MASK, 32'h00000003);
    rd(itb_pkg::ADDR_MASK, 32'h00000001, 32'h00000001);
    fork
      wr(itb_pkg::ADDR_BRANCH, 32'h00000006);
      begin
        repeat (2) @(posedge pclk);
        ev[0] <= 1'b1;
        @(posedge pclk);
        ev[0] <= 1'b0;
      end
    join
    st(32'h00080040, 32'h000800c0);
    repeat (itb_pkg::T_NOT) @(posedge pclk);
    rd(itb_pkg::ADDR_RESULT, 32'h00000002, 32'h00fffff7);
    pulse(15);
    st(32'h00000000, 32'h000800c0);
    finish_test();
  end
endmodule
